// ### logic/port_auth_pkg.sv
// Constants, field layout and enumerations for port admission and uplink control
// Overview of operation
// - Control-five bit 2 enables access-list filtering per port; resets to zero.
// - Control-five bits 1:0 hold the authentication policy; resets to 00.
// - Policy 00 or 10 without filtering forwards all traffic as forced-authorized.
// - Open policy with filtering on still forwards frames that miss the list.
// - Policy 01 without filtering blocks every received frame.
// - Policy 01 with filtering blocks misses; hits follow the entry's action.
// - Policy 11 without filtering sends every frame only to the CPU port.
// - Policy 11 with filtering traps misses to port 5; hits follow entry.
// - Control-six addresses of ports 1 to 4 are reserved, no function.
// - Uplink interface control register decodes at 0x56.
// - Uplink bit 7 selects internal (1) or external (0) reduced-MII clock.
// - Bit 7 reset value follows its strap; pull-up selects internal clock.
// - Uplink bit 6 selects gigabit (1) or 10/100 (0) operation.
// - Bit 6 reset value follows its strap; pull-up selects gigabit.
// - In 10/100 mode the 10 or 100 choice comes from a global bit 4.
// - Bit 4 adds receive clock internal delay of at least 1.5 ns; resets 0.
// - Bit 3 adds transmit clock internal delay of at least 1.5 ns; resets 1.
// - Control-five registers decode at 0x15, 0x25, 0x35, 0x45 and 0x55.
package port_auth_pkg;

    // Address layout: high nibble is port number, low nibble the register
    localparam logic [3:0] CTRL5_LOW       = 4'h5;
    localparam logic [3:0] CTRL6_LOW       = 4'h6;
    localparam logic [7:0] UPLINK_CTRL_ADDR = 8'h56;
    localparam int         MAX_PORTS       = 7;

    // Control-five fields
    localparam int         FILTER_ON_BIT   = 2;
    localparam int         POLICY_HI       = 1;
    localparam int         POLICY_LO       = 0;
    localparam logic       FILTER_ON_RST   = 1'b0;
    localparam logic [1:0] POLICY_RST      = 2'h0;
    localparam logic [4:0] CTRL5_RSVD_VAL  = 5'h00;

    // Policy encodings
    localparam logic [1:0] POLICY_OPEN     = 2'h0;
    localparam logic [1:0] POLICY_BLOCK    = 2'h1;
    localparam logic [1:0] POLICY_OPEN_ALT = 2'h2;
    localparam logic [1:0] POLICY_TRAP     = 2'h3;

    // Uplink interface control fields
    localparam int         RMII_CLK_BIT    = 7;
    localparam int         GIGABIT_BIT     = 6;
    localparam int         RSVD5_BIT       = 5;
    localparam int         RX_DELAY_BIT    = 4;
    localparam int         TX_DELAY_BIT    = 3;
    localparam logic       RSVD5_VAL       = 1'b1;
    localparam logic [2:0] UPLINK_LOW_VAL  = 3'h0;
    localparam logic       RX_DELAY_RST    = 1'b0;
    localparam logic       TX_DELAY_RST    = 1'b1;
    localparam logic       RMII_CLK_PULLUP = 1'b1;
    localparam logic       GIGABIT_PULLUP  = 1'b1;

    // Least internal clock delay the pad delay cell must add, in ps
    localparam int         CLOCK_DELAY_MIN_PS = 1500;

    // Cycles after reset release before strap levels are trusted
    localparam logic [2:0] STRAP_SETTLE    = 3'h4;

    // Port index of the CPU uplink (port 5)
    localparam logic [2:0] CPU_PORT_INDEX  = 3'h4;

    localparam logic [7:0] READ_ZERO       = 8'h00;

    typedef enum logic [1:0] {
        VERDICT_FORWARD,
        VERDICT_BLOCK,
        VERDICT_TRAP_CPU,
        VERDICT_ENTRY_ACTION
    } verdict_e;

endpackage

// ### logic/level_sync3.sv
// Three-flop level synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module level_sync3 #(
    parameter int              WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic             i_enable,
    // Levels
    input  wire logic [WIDTH-1:0] i_level,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & o_level);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1  <= RESET_VAL;
            stage2  <= RESET_VAL;
            stage3  <= RESET_VAL;
            o_level <= RESET_VAL;
        end else if (i_enable) begin
            stage1  <= i_level;
            stage2  <= stage1;
            stage3  <= stage2;
            o_level <= next_level;
        end
    end
endmodule // level_sync3
`default_nettype wire

// ### logic/port_auth_and_uplink_config.sv
// Per-port admission policy registers, frame verdicts and uplink interface control
`timescale 1ns/1ns
`default_nettype none
module port_auth_and_uplink_config #(
    parameter int NUM_PORTS = 5
) (
    // Core clock, reset, enable
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_clock_en,
    // Register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_write,
    input  wire logic       i_reg_read,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_rvalid,
    // Strap pins
    input  wire logic       i_strap_rmii_clock,
    input  wire logic       i_strap_gigabit,
    // Global speed bit for 10/100 mode, high selects 100
    input  wire logic       i_global_speed_100,
    // Frame admission request
    input  wire logic       i_frame_valid,
    input  wire logic [2:0] i_frame_port,
    input  wire logic       i_list_hit,
    // Frame admission verdict
    output logic            o_verdict_valid,
    output port_auth_pkg::verdict_e o_verdict,
    output logic      [2:0] o_verdict_dest,
    // Link clock domain
    input  wire logic       i_link_clock,
    output logic            o_link_rmii_internal_clock,
    output logic            o_link_speed_1000,
    output logic            o_link_speed_100,
    output logic            o_link_speed_10,
    output logic            o_link_rx_clock_delay,
    output logic            o_link_tx_clock_delay
);
    initial begin
        if (NUM_PORTS < 1 || NUM_PORTS > port_auth_pkg::MAX_PORTS) begin
            $error("NUM_PORTS must lie between 1 and 7");
        end
    end

    // Address decode
    wire  [3:0] addr_hi    = i_reg_addr[7:4];
    wire  [3:0] addr_lo    = i_reg_addr[3:0];
    wire  [3:0] port_num   = addr_hi - 4'h1;
    wire  [2:0] reg_port   = port_num[2:0];
    wire        port_ok    = (addr_hi >= 4'h1) && (addr_hi <= 4'(NUM_PORTS));
    wire        hit_ctrl5  = port_ok && (addr_lo == port_auth_pkg::CTRL5_LOW);
    wire        hit_uplink = (i_reg_addr == port_auth_pkg::UPLINK_CTRL_ADDR);
    wire        wr_ctrl5   = i_clock_en && i_reg_write && hit_ctrl5;
    wire        wr_uplink  = i_clock_en && i_reg_write && hit_uplink;

    // Per-port admission state
    logic       filter_on [NUM_PORTS];
    logic [1:0] policy    [NUM_PORTS];

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        wire wr_this = wr_ctrl5 && (reg_port == 3'(p));
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                filter_on[p] <= port_auth_pkg::FILTER_ON_RST;
                policy[p]    <= port_auth_pkg::POLICY_RST;
            end else if (wr_this) begin
                filter_on[p] <= i_reg_wdata[port_auth_pkg::FILTER_ON_BIT];
                policy[p]    <= i_reg_wdata[port_auth_pkg::POLICY_HI:port_auth_pkg::POLICY_LO];
            end
        end
    end

    // Strap capture after reset release, through the pin synchroniser
    logic       strap_rmii_s;
    logic       strap_gig_s;
    logic [2:0] settle_count;
    logic       strap_done;
    wire        strap_load = !strap_done && (settle_count == port_auth_pkg::STRAP_SETTLE);

    level_sync3 #(
        .WIDTH     (2),
        .RESET_VAL ({port_auth_pkg::RMII_CLK_PULLUP, port_auth_pkg::GIGABIT_PULLUP})
    ) u_strap_sync (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_enable (i_clock_en),
        .i_level  ({i_strap_rmii_clock, i_strap_gigabit}),
        .o_level  ({strap_rmii_s, strap_gig_s})
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_count <= 3'h0;
            strap_done   <= 1'b0;
        end else if (i_clock_en && !strap_done) begin
            settle_count <= settle_count + 3'h1;
            strap_done   <= strap_load;
        end
    end

    // Uplink interface control bits
    logic rmii_internal_clock;
    logic gigabit;
    logic rx_delay;
    logic tx_delay;

    // Strap load precedes software; a write in the load cycle still wins
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rmii_internal_clock <= port_auth_pkg::RMII_CLK_PULLUP;
            gigabit             <= port_auth_pkg::GIGABIT_PULLUP;
            rx_delay            <= port_auth_pkg::RX_DELAY_RST;
            tx_delay            <= port_auth_pkg::TX_DELAY_RST;
        end else if (wr_uplink) begin
            rmii_internal_clock <= i_reg_wdata[port_auth_pkg::RMII_CLK_BIT];
            gigabit             <= i_reg_wdata[port_auth_pkg::GIGABIT_BIT];
            rx_delay            <= i_reg_wdata[port_auth_pkg::RX_DELAY_BIT];
            tx_delay            <= i_reg_wdata[port_auth_pkg::TX_DELAY_BIT];
        end else if (i_clock_en && strap_load) begin
            rmii_internal_clock <= strap_rmii_s;
            gigabit             <= strap_gig_s;
        end
    end

    // Read data; reserved fields and unmapped addresses read fixed values
    wire  [7:0] ctrl5_value  = {port_auth_pkg::CTRL5_RSVD_VAL, filter_on[reg_port],
                                policy[reg_port]};
    wire  [7:0] uplink_value = {rmii_internal_clock, gigabit, port_auth_pkg::RSVD5_VAL,
                                rx_delay, tx_delay, port_auth_pkg::UPLINK_LOW_VAL};
    wire  [7:0] next_rdata   = hit_ctrl5  ? ctrl5_value  :
                               hit_uplink ? uplink_value :
                               port_auth_pkg::READ_ZERO;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= port_auth_pkg::READ_ZERO;
            o_reg_rvalid <= 1'b0;
        end else if (i_clock_en) begin
            o_reg_rdata  <= i_reg_read ? next_rdata : o_reg_rdata;
            o_reg_rvalid <= i_reg_read;
        end
    end

    // Frame verdict
    wire        frame_port_ok = (i_frame_port < 3'(NUM_PORTS));
    wire        sel_filter    = frame_port_ok && filter_on[i_frame_port];
    wire  [1:0] sel_policy    = frame_port_ok ? policy[i_frame_port] : port_auth_pkg::POLICY_BLOCK;
    wire        entry_decides = sel_filter && i_list_hit;
    wire        open_policy   = (sel_policy == port_auth_pkg::POLICY_OPEN) ||
                                (sel_policy == port_auth_pkg::POLICY_OPEN_ALT);
    // Misses and unfiltered frames fall to the policy alone
    wire port_auth_pkg::verdict_e next_verdict =
        entry_decides                              ? port_auth_pkg::VERDICT_ENTRY_ACTION :
        open_policy                                ? port_auth_pkg::VERDICT_FORWARD :
        (sel_policy == port_auth_pkg::POLICY_TRAP) ? port_auth_pkg::VERDICT_TRAP_CPU :
                                                     port_auth_pkg::VERDICT_BLOCK;
    wire  [2:0] next_dest = (next_verdict == port_auth_pkg::VERDICT_TRAP_CPU) ?
                            port_auth_pkg::CPU_PORT_INDEX : 3'h0;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_verdict_valid <= 1'b0;
            o_verdict       <= port_auth_pkg::VERDICT_BLOCK;
            o_verdict_dest  <= 3'h0;
        end else if (i_clock_en) begin
            o_verdict_valid <= i_frame_valid;
            o_verdict       <= i_frame_valid ? next_verdict : o_verdict;
            o_verdict_dest  <= i_frame_valid ? next_dest : o_verdict_dest;
        end
    end

    // Link domain: quasi-static settings cross bit by bit, so a write may
    // appear on the link a bit at a time over one or two link cycles
    logic link_gigabit;
    logic link_fast;

    level_sync3 #(
        .WIDTH     (5),
        .RESET_VAL ({port_auth_pkg::RMII_CLK_PULLUP, port_auth_pkg::GIGABIT_PULLUP,
                     port_auth_pkg::RX_DELAY_RST, port_auth_pkg::TX_DELAY_RST, 1'b0})
    ) u_link_sync (
        .i_clock  (i_link_clock),
        .i_rst_n  (i_rst_n),
        .i_enable (1'b1),
        .i_level  ({rmii_internal_clock, gigabit, rx_delay, tx_delay, i_global_speed_100}),
        .o_level  ({o_link_rmii_internal_clock, link_gigabit, o_link_rx_clock_delay,
                    o_link_tx_clock_delay, link_fast})
    );

    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_link_speed_1000 <= port_auth_pkg::GIGABIT_PULLUP;
            o_link_speed_100  <= 1'b0;
            o_link_speed_10   <= 1'b0;
        end else begin
            o_link_speed_1000 <= link_gigabit;
            o_link_speed_100  <= !link_gigabit && link_fast;
            o_link_speed_10   <= !link_gigabit && !link_fast;
        end
    end

    // Checks
    entry_action_hit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_frame_valid && sel_filter && i_list_hit
        |=> o_verdict_valid && o_verdict == port_auth_pkg::VERDICT_ENTRY_ACTION)
        else $error("list hit did not defer to entry action");
    open_forward_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_frame_valid && frame_port_ok && open_policy && !entry_decides
        |=> o_verdict == port_auth_pkg::VERDICT_FORWARD)
        else $error("open policy did not forward");
    block_miss_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_frame_valid && sel_policy == port_auth_pkg::POLICY_BLOCK
        && !entry_decides |=> o_verdict == port_auth_pkg::VERDICT_BLOCK)
        else $error("block policy did not block");
    trap_cpu_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_frame_valid && sel_policy == port_auth_pkg::POLICY_TRAP
        && !entry_decides |=> o_verdict == port_auth_pkg::VERDICT_TRAP_CPU
        && o_verdict_dest == port_auth_pkg::CPU_PORT_INDEX)
        else $error("trap policy did not send to CPU port");
    reserved_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_reg_read && addr_lo == port_auth_pkg::CTRL6_LOW && !hit_uplink
        |=> o_reg_rvalid && o_reg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    uplink_fixed_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && i_reg_read && hit_uplink
        |=> o_reg_rdata[5] && o_reg_rdata[2:0] == 3'h0)
        else $error("uplink reserved bits wrong");
    ctrl5_readback_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_clock_en && wr_ctrl5 ##1 i_clock_en && i_reg_read && hit_ctrl5
        && i_reg_addr == $past(i_reg_addr)
        |=> o_reg_rdata == {5'h00, $past(i_reg_wdata, 2) & 8'h07})
        else $error("control-five write not read back");
    strap_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(strap_done) && !$past(wr_uplink)
        |-> rmii_internal_clock == $past(strap_rmii_s) && gigabit == $past(strap_gig_s))
        else $error("strap levels not loaded");
    link_speed_a: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
        !link_gigabit |=> !o_link_speed_1000 && (o_link_speed_100 != o_link_speed_10))
        else $error("10/100 speed selection wrong");
endmodule // port_auth_and_uplink_config
`default_nettype wire

// ### tb/uplink_host_model.sv
// Host MAC at the far end of the uplink, choosing its own clock delays
`timescale 1ns/1ns
`default_nettype none
module uplink_host_model (
    // Link clock and reset
    input  wire logic i_link_clock,
    input  wire logic i_rst_n,
    // Switch side delay enables
    input  wire logic i_switch_rx_delay,
    input  wire logic i_switch_tx_delay,
    // Own delay enables
    output logic      o_host_tx_delay,
    output logic      o_host_rx_delay
);
    // Each clock must be delayed exactly once across the link
    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_tx_delay <= 1'b1;
            o_host_rx_delay <= 1'b0;
        end else begin
            o_host_tx_delay <= ~i_switch_rx_delay;
            o_host_rx_delay <= ~i_switch_tx_delay;
        end
    end
endmodule // uplink_host_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for port admission policy and uplink interface control
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic i_clock, i_rst_n, i_clock_en, i_link_clock;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic i_reg_write, i_reg_read, o_reg_rvalid;
    logic i_strap_rmii_clock, i_strap_gigabit, i_global_speed_100;
    logic i_frame_valid, i_list_hit, o_verdict_valid;
    logic [2:0] i_frame_port, o_verdict_dest;
    port_auth_pkg::verdict_e o_verdict;
    logic o_link_rmii_internal_clock, o_link_speed_1000, o_link_speed_100, o_link_speed_10;
    logic o_link_rx_clock_delay, o_link_tx_clock_delay, host_tx_delay, host_rx_delay;
    int   err_count, samples_checked, cycle_count;

    port_auth_and_uplink_config #(.NUM_PORTS(5)) i_port_auth_and_uplink_config (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clock_en(i_clock_en),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
        .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_strap_rmii_clock(i_strap_rmii_clock), .i_strap_gigabit(i_strap_gigabit),
        .i_global_speed_100(i_global_speed_100), .i_frame_valid(i_frame_valid),
        .i_frame_port(i_frame_port), .i_list_hit(i_list_hit),
        .o_verdict_valid(o_verdict_valid), .o_verdict(o_verdict),
        .o_verdict_dest(o_verdict_dest), .i_link_clock(i_link_clock),
        .o_link_rmii_internal_clock(o_link_rmii_internal_clock),
        .o_link_speed_1000(o_link_speed_1000), .o_link_speed_100(o_link_speed_100),
        .o_link_speed_10(o_link_speed_10), .o_link_rx_clock_delay(o_link_rx_clock_delay),
        .o_link_tx_clock_delay(o_link_tx_clock_delay));

    uplink_host_model i_uplink_host_model (
        .i_link_clock(i_link_clock), .i_rst_n(i_rst_n),
        .i_switch_rx_delay(o_link_rx_clock_delay), .i_switch_tx_delay(o_link_tx_clock_delay),
        .o_host_tx_delay(host_tx_delay), .o_host_rx_delay(host_rx_delay));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Odd start offset staggers the link clock from the core clock; every fifth link edge still lands on a core edge
    initial begin
        i_link_clock = 1'b0;
        #7;
        forever #32 i_link_clock = ~i_link_clock;
    end

    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycle_count++;
        if (cycle_count == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_clock);
        i_reg_addr = addr;
        i_reg_wdata = data;
        i_reg_write = 1'b1;
        @(negedge i_clock);
        i_reg_write = 1'b0;
    endtask

    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        int n;
        @(negedge i_clock);
        i_reg_addr = addr;
        i_reg_read = 1'b1;
        @(negedge i_clock);
        i_reg_read = 1'b0;
        n = 0;
        while (o_reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        check(o_reg_rdata, exp);
    endtask

    task automatic frame(input logic [2:0] port, input logic hit, input logic [1:0] ev,
                         input logic [2:0] ed);
        int n;
        @(negedge i_clock);
        i_frame_port = port;
        i_list_hit = hit;
        i_frame_valid = 1'b1;
        @(negedge i_clock);
        i_frame_valid = 1'b0;
        n = 0;
        while (o_verdict_valid !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        check({3'h0, ed, 2'(o_verdict)}, {3'h0, o_verdict_dest, ev});
    endtask

    task automatic test_reset_values();
        for (int p = 1; p <= 5; p++) check_reg({4'(p), 4'h5}, 8'h00);
        check_reg(8'h56, 8'he8);
        for (int p = 1; p <= 4; p++) check_reg({4'(p), 4'h6}, 8'h00);
        check_reg(8'h57, 8'h00);
    endtask

    task automatic test_reserved_writes();
        reg_write(8'h25, 8'hff);
        check_reg(8'h25, 8'h07);
        check_reg(8'h15, 8'h00);
        // Frozen enable must swallow the write
        @(negedge i_clock);
        i_clock_en = 1'b0;
        reg_write(8'h15, 8'h07);
        i_clock_en = 1'b1;
        check_reg(8'h15, 8'h00);
        // Back-to-back write then read of the same register
        @(negedge i_clock);
        i_reg_addr = 8'h45;
        i_reg_wdata = 8'h06;
        i_reg_write = 1'b1;
        @(negedge i_clock);
        i_reg_write = 1'b0;
        i_reg_read = 1'b1;
        @(negedge i_clock);
        i_reg_read = 1'b0;
        check(o_reg_rdata, 8'h06);
        reg_write(8'h56, 8'h07);
        check_reg(8'h56, 8'h20);
        reg_write(8'h36, 8'hff);
        check_reg(8'h36, 8'h00);
    endtask

    task automatic test_verdicts();
        logic [1:0] ev;
        for (int pol = 0; pol < 4; pol++) begin
            for (int f = 0; f < 2; f++) begin
                reg_write({4'(pol + 1), 4'h5}, {5'h00, 1'(f), 2'(pol)});
                for (int h = 0; h < 2; h++) begin
                    // Filter hits override the port policy
                    ev = (f == 1 && h == 1) ? port_auth_pkg::VERDICT_ENTRY_ACTION :
                         (pol == 1) ? port_auth_pkg::VERDICT_BLOCK :
                         (pol == 3) ? port_auth_pkg::VERDICT_TRAP_CPU :
                         port_auth_pkg::VERDICT_FORWARD;
                    frame(3'(pol), 1'(h), ev,
                          (ev == port_auth_pkg::VERDICT_TRAP_CPU) ? 3'h4 : 3'h0);
                end
            end
        end
        frame(3'h5, 1'b0, port_auth_pkg::VERDICT_BLOCK, 3'h0);
    endtask

    task automatic test_link();
        logic [7:0] vals [4] = '{8'he8, 8'h10, 8'h10, 8'h88};
        logic       gs   [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int k = 0; k < 4; k++) begin
            reg_write(8'h56, vals[k]);
            i_global_speed_100 = gs[k];
            repeat (12) @(posedge i_link_clock);
            @(negedge i_clock);
            check({2'h0, o_link_rmii_internal_clock, o_link_speed_1000, o_link_speed_100,
                   o_link_speed_10, o_link_rx_clock_delay, o_link_tx_clock_delay},
                  {2'h0, vals[k][7], vals[k][6], ~vals[k][6] & gs[k], ~vals[k][6] & ~gs[k],
                   vals[k][4], vals[k][3]});
            check({6'h0, o_link_rx_clock_delay ^ host_tx_delay,
                   o_link_tx_clock_delay ^ host_rx_delay}, 8'h03);
        end
    endtask

    task automatic test_strap_low();
        @(negedge i_clock);
        i_rst_n = 1'b0;
        i_strap_rmii_clock = 1'b0;
        i_strap_gigabit = 1'b0;
        repeat (20) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (10) @(negedge i_clock);
        check_reg(8'h56, 8'h28);
        check_reg(8'h25, 8'h00);
        reg_write(8'h56, 8'hc0);
        check_reg(8'h56, 8'he0);
    endtask

    initial begin
        err_count = 0;
        samples_checked = 0;
        cycle_count = 0;
        i_rst_n = 1'b0;
        i_clock_en = 1'b1;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_reg_write = 1'b0;
        i_reg_read = 1'b0;
        i_strap_rmii_clock = 1'b1;
        i_strap_gigabit = 1'b1;
        i_global_speed_100 = 1'b1;
        i_frame_valid = 1'b0;
        i_frame_port = 3'h0;
        i_list_hit = 1'b0;
        repeat (20) @(negedge i_clock);
        i_rst_n = 1'b1;
        // Straps settle before the first uplink write
        repeat (10) @(negedge i_clock);
        test_reset_values();
        test_reserved_writes();
        test_verdicts();
        test_link();
        test_strap_low();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
